// ===== diag_cfg_checker_assertions.sv
`timescale 1ns/10ps
module diag_cfg_checker (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic strap_mode_i,
	input wire logic crc_enable_pin_i,
	input wire logic addr0_wd_enable_pin_i,
	input wire logic addr1_sync_wd_enable_pin_i,
	input wire logic supply_uvlo_i,
	input wire logic turn_on_threshold_select_o,
	input wire logic comm_error_flag_o,
	input wire logic supply_error_flag_o,
	input wire logic global_flag_o,
	input wire logic voltage_error_bit_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	// Pins pass a two-flop synchroniser, so four samples are allowed before the effect
	strap_turnon_a: assert property (strap_mode_i [*4] |=> turn_on_threshold_select_o)
		else $error("turn-on select not forced");
	voltage_error_bit_set_a: assert property ((strap_mode_i && crc_enable_pin_i && supply_uvlo_i) [*4] |=> voltage_error_bit_o)
		else $error("voltage error bit missing");
	voltage_error_bit_nocrc_a: assert property (!crc_enable_pin_i [*4] |=> !voltage_error_bit_o)
		else $error("voltage error bit without crc pin");
	voltage_error_bit_nostrap_a: assert property (!strap_mode_i [*4] |=> !voltage_error_bit_o)
		else $error("voltage error bit outside strap mode");
	uvlo_flag_a: assert property ((supply_uvlo_i && !strap_mode_i) [*3] |-> ##[0:4] supply_error_flag_o)
		else $error("lockout not in supply flag");
	comm_glob_a: assert property ($rose(comm_error_flag_o) |-> ##[0:3] global_flag_o)
		else $error("comm error not in global flag");
	supply_glob_a: assert property ($rose(supply_error_flag_o) |-> ##[0:3] global_flag_o)
		else $error("supply error not in global flag");
	// Without enable straps no watchdog may run in strap mode
	strap_nowd_a: assert property ((strap_mode_i && !addr0_wd_enable_pin_i && !addr1_sync_wd_enable_pin_i) [*6]
		|=> !$rose(comm_error_flag_o))
		else $error("watchdog ran without enable straps");
endmodule : diag_cfg_checker

bind diag_led_watchdog_config_regs diag_cfg_checker chk (.mclk_i, .rst_i, .strap_mode_i, .crc_enable_pin_i,
	.addr0_wd_enable_pin_i, .addr1_sync_wd_enable_pin_i, .supply_uvlo_i, .turn_on_threshold_select_o,
	.comm_error_flag_o, .supply_error_flag_o, .global_flag_o, .voltage_error_bit_o);

// ===== diag_cfg_pkg.sv
package diag_cfg_pkg;

	// Register offsets on the serial link
	localparam logic [6:0] OFS_OVERLOAD    = 7'h04;
	localparam logic [6:0] OFS_OVERCURRENT = 7'h05;
	localparam logic [6:0] OFS_OPEN_OFF    = 7'h06;
	localparam logic [6:0] OFS_OPEN_ON     = 7'h07;
	localparam logic [6:0] OFS_SHORT       = 7'h08;
	localparam logic [6:0] OFS_GLOBAL      = 7'h09;
	localparam logic [6:0] OFS_LED_CFG     = 7'h0d;
	localparam logic [6:0] OFS_WD_CFG      = 7'h0e;
	localparam logic [6:0] OFS_MASK        = 7'h0f;

	// Values after reset
	localparam logic [7:0] RST_LED_CFG = 8'h53;
	localparam logic [7:0] RST_WD_CFG  = 8'h00;
	localparam logic [7:0] RST_MASK    = 8'hbe;

	// led_filter_config fields
	localparam int LC_OC_MASK = 7;
	localparam int LC_LATCH   = 6;
	localparam int LC_LONG    = 5;
	localparam int LC_FILTER  = 4;
	localparam int LC_STRETCH = 2;
	localparam int LC_STATUS_LED_SW = 1;
	localparam int LC_FAULT_LED_SW = 0;
	// watchdog_threshold_config fields
	localparam int WC_TIMEOUT = 6;
	localparam int WC_PULLUP  = 4;
	localparam int WC_SHORT   = 2;
	localparam int WC_SYNC_EN = 1;
	localparam int WC_TURN_ON = 0;
	// fault_pin_mask fields
	localparam int MK_COMM     = 7;
	localparam int MK_SUPPLY   = 6;
	localparam int MK_OK       = 5;
	localparam int MK_SHORT    = 4;
	localparam int MK_OPEN_ON  = 3;
	localparam int MK_OPEN_OFF = 2;
	localparam int MK_OC       = 1;
	localparam int MK_OVL      = 0;
	// Global error byte fields
	localparam int GE_SPI_WD   = 7;
	localparam int GE_SYNC_WD  = 6;
	localparam int GE_UVLO     = 4;
	localparam int GE_WARN     = 3;
	localparam int GE_NOT_GOOD = 2;

	// Serial frame: write flag, 7-bit address, 8-bit data
	localparam logic [4:0] FRAME_BITS = 5'd16;
	localparam logic [4:0] HDR_LAST   = 5'd7;

	// Times in their own units and the derived cycle counts
	localparam int CLK_MHZ        = 100;
	localparam int BLANK_SHORT_US = 4000;
	localparam int BLANK_LONG_US  = 8000;
	localparam int DEGLITCH_US    = 50;
	localparam int STRETCH_MS     = 1000;
	localparam int WD_SHORT_MS    = 200;
	localparam int WD_MID_MS      = 600;
	localparam int WD_LONG_MS     = 1200;
	localparam int BLANK_SHORT_CYC = BLANK_SHORT_US * CLK_MHZ;
	localparam int BLANK_LONG_CYC  = BLANK_LONG_US * CLK_MHZ;
	localparam int DEGLITCH_CYC    = DEGLITCH_US * CLK_MHZ;
	localparam int STRETCH_CYC     = STRETCH_MS * 1000 * CLK_MHZ;
	localparam int WD_SHORT_CYC    = WD_SHORT_MS * 1000 * CLK_MHZ;
	localparam int WD_MID_CYC      = WD_MID_MS * 1000 * CLK_MHZ;
	localparam int WD_LONG_CYC     = WD_LONG_MS * 1000 * CLK_MHZ;

	typedef struct packed {
		logic [7:0] overload;
		logic [7:0] overcurrent;
		logic [7:0] open_off;
		logic [7:0] open_on;
		logic [7:0] short_supply;
	} diag_t;

	typedef struct packed {
		logic       wr;
		logic [6:0] addr;
		logic [7:0] data;
	} link_ev_t;

	typedef struct packed {
		diag_t      diag;
		logic [7:0] glob;
		logic [7:0] led_cfg;
		logic [7:0] wd_cfg;
		logic [7:0] mask;
	} snap_t;

endpackage : diag_cfg_pkg

// ===== diag_led_watchdog_config_regs.sv
`timescale 1ns/10ps
// Functional notes
// [R1] Mask bit keeps overcurrent off internal fault LEDs; strap mode never shows it.
// [R2] Latch enable makes per-channel diagnostic flags sticky, cleared by reading them.
// [R3] Internal fault LEDs ignore latching, hold minimum stretch, then follow the fault.
// [R4] Long bit picks 8ms blanking, else 4ms, for open/short flags and LED turn-on.
// [R5] Filter enable blanks open/short flags; otherwise only a 50us deglitch.
// [R6] Internal fault LED path is always blanked regardless of filter enable.
// [R7] Stretch field: 00 none, 01 1s, 10 2s, 11 3s minimum LED on-time.
// [R8] Strap mode forces 2s minimum fault LED on-time.
// [R9] Status LEDs follow software register when selected; strap forces internal drive.
// [R10] Fault LEDs follow software or diagnostics; strap uses overload only.
// [R11] Watchdog field: 00 SPI off/sync 600ms, 01 200ms, 10 600ms, 11 1.2s.
// [R12] Strap mode fixes both watchdogs at 1.2s, enabled by address pins.
// [R13] Two-bit field selects open-wire pull-up current 20/100/300/600uA.
// [R14] Two-bit field selects short-to-supply threshold 9/10/12/14V.
// [R15] Turn-on threshold bit picks good level or lockout level; strap uses good.
// [R16] Comm mask keeps watchdog timeouts off fault pin; flags still set.
// [R17] Strap: watchdogs never reach fault pin; comm flag only with CRC pin high.
// [R18] Supply mask keeps supply errors off fault pin; flags still set.
// [R19] Strap: supply errors never on fault pin; voltage bit only with CRC high.
// [R20] Supply-OK mask drops not-good and warning from supply error aggregate.
// [R21] Fault pin active while any enabled unmasked fault class or latched flag remains.
module diag_led_watchdog_config_regs #(
	parameter int BLANK_SHORT = diag_cfg_pkg::BLANK_SHORT_CYC,
	parameter int BLANK_LONG  = diag_cfg_pkg::BLANK_LONG_CYC,
	parameter int DEGLITCH    = diag_cfg_pkg::DEGLITCH_CYC,
	parameter int STRETCH     = diag_cfg_pkg::STRETCH_CYC,
	parameter int WD_SHORT    = diag_cfg_pkg::WD_SHORT_CYC,
	parameter int WD_MID      = diag_cfg_pkg::WD_MID_CYC,
	parameter int WD_LONG     = diag_cfg_pkg::WD_LONG_CYC
) (
	input  wire logic                mclk_i,
	input  wire logic                rst_i,
	input  wire logic                sclk_i,
	input  wire logic                cs_n_i,
	input  wire logic                sdi_i,
	output logic                     sdo_o,
	output logic                     sdo_oe_o,
	input  wire logic                strap_mode_i,
	input  wire logic                crc_enable_pin_i,
	input  wire logic                addr0_wd_enable_pin_i,
	input  wire logic                addr1_sync_wd_enable_pin_i,
	input  wire logic                sync_i,
	input  wire diag_cfg_pkg::diag_t diag_raw_i,
	input  wire logic [7:0]          channel_on_i,
	input  wire logic [7:0]          status_led_sw_reg_i,
	input  wire logic [7:0]          fault_led_sw_reg_i,
	input  wire logic                supply_uvlo_i,
	input  wire logic                supply_not_good_flag_i,
	input  wire logic                supply_warn_flag_i,
	output diag_cfg_pkg::diag_t      diag_flags_o,
	output logic [7:0]               fault_led_o,
	output logic [7:0]               status_led_o,
	output logic                     fault_out_o,
	output logic                     fault_oe_o,
	output logic [1:0]               pullup_current_sel_o,
	output logic [1:0]               short_thresh_sel_o,
	output logic                     turn_on_threshold_select_o,
	output logic                     comm_error_flag_o,
	output logic                     supply_error_flag_o,
	output logic                     global_flag_o,
	output logic                     voltage_error_bit_o
);
	import diag_cfg_pkg::*;

	// Persistence filter step: count while raw is high, drop to zero when low
	function automatic logic [19:0] filt_step(input logic raw, input logic [19:0] cnt, input logic [19:0] lim);
		filt_step = !raw ? 20'h00000 : (cnt >= lim) ? cnt : cnt + 20'h00001;
	endfunction : filt_step

	// Byte readable at an address, zero when unmapped
	function automatic logic [7:0] read_byte(input snap_t s, input logic [6:0] a);
		case (a)
			OFS_OVERLOAD:    read_byte = s.diag.overload;
			OFS_OVERCURRENT: read_byte = s.diag.overcurrent;
			OFS_OPEN_OFF:    read_byte = s.diag.open_off;
			OFS_OPEN_ON:     read_byte = s.diag.open_on;
			OFS_SHORT:       read_byte = s.diag.short_supply;
			OFS_GLOBAL:      read_byte = s.glob;
			OFS_LED_CFG:     read_byte = s.led_cfg;
			OFS_WD_CFG:      read_byte = s.wd_cfg;
			OFS_MASK:        read_byte = s.mask;
			default:         read_byte = 8'h00;
		endcase
	endfunction : read_byte

	// ---------------- Link domain (serial clock) ----------------
	logic [4:0] bit_cnt_r;
	logic [6:0] shift_in_r;
	logic [7:0] hdr_r;
	logic [7:0] sdo_sh_r;
	logic       sdo_oe_r;
	link_ev_t   ev_word_r;
	logic       ev_tog_r;
	snap_t      snap_l_r;
	logic       ack_tog_r;
	logic [1:0] snap_tog_l_sync_r;
	snap_t      snap_r;
	logic       snap_tog_r;

	// Frame shifter; chip select high clears it, so a cut frame leaves nothing behind
	always_ff @(posedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			bit_cnt_r  <= 5'd0;
			shift_in_r <= 7'h00;
			hdr_r      <= 8'h00;
			sdo_sh_r   <= 8'h00;
			sdo_oe_r   <= 1'b0;
		end else begin
			sdo_oe_r   <= 1'b1;
			shift_in_r <= {shift_in_r[5:0], sdi_i};
			if (bit_cnt_r != FRAME_BITS)
				bit_cnt_r <= bit_cnt_r + 5'd1;
			if (bit_cnt_r == HDR_LAST) begin
				hdr_r    <= {shift_in_r, sdi_i};
				sdo_sh_r <= read_byte(snap_l_r, shift_in_r[5:0] == 6'h00 ? {shift_in_r[5:0], sdi_i} :
				            {shift_in_r[5:0], sdi_i});
			end else begin
				sdo_sh_r <= {sdo_sh_r[6:0], 1'b0};
			end
		end
	end
	assign sdo_o    = sdo_sh_r[7];
	assign sdo_oe_o = sdo_oe_r;

	// Completed frame is posted as one word with a toggle; the word holds for a whole frame
	always_ff @(posedge sclk_i or posedge rst_i) begin
		if (rst_i) begin
			ev_word_r <= '0;
			ev_tog_r  <= 1'b0;
		end else if (!cs_n_i && bit_cnt_r == FRAME_BITS - 5'd1) begin
			ev_word_r.wr   <= hdr_r[7];
			ev_word_r.addr <= hdr_r[6:0];
			ev_word_r.data <= hdr_r[7] ? {shift_in_r, sdi_i} : read_byte(snap_l_r, hdr_r[6:0]);
			ev_tog_r       <= ~ev_tog_r;
		end
	end

	// Snapshot via toggle handshake; frozen from the reply byte so a read clears what it sent
	always_ff @(posedge sclk_i or posedge rst_i) begin
		if (rst_i) begin
			snap_tog_l_sync_r <= 2'b00;
			snap_l_r          <= '0;
			ack_tog_r         <= 1'b0;
		end else begin
			snap_tog_l_sync_r <= {snap_tog_l_sync_r[0], snap_tog_r};
			if (snap_tog_l_sync_r[1] != ack_tog_r && bit_cnt_r < HDR_LAST) begin
				snap_l_r  <= snap_r;
				ack_tog_r <= snap_tog_l_sync_r[1];
			end
		end
	end

	// ---------------- Main domain ----------------
	logic [2:0] ev_sync_r;
	logic [1:0] ack_sync_r;
	logic [4:0] pin_meta_r;
	logic [4:0] pin_r;
	logic       sync_prev_r;
	logic [7:0] led_cfg_r;
	logic [7:0] wd_cfg_r;
	logic [7:0] mask_r;
	diag_t      flags_r;
	logic [19:0] filt_cnt_r [24];
	logic [19:0] led_cnt_r [8];
	logic [28:0] stretch_r [8];
	logic [26:0] spi_wd_cnt_r;
	logic [26:0] sync_wd_cnt_r;
	logic        spi_wd_err_r;
	logic        sync_wd_err_r;
	logic        frame_seen;
	logic        clr_global;
	logic        strap;
	logic        crc_en;
	logic [19:0] diag_lim;
	logic [19:0] led_lim;
	logic [28:0] stretch_lim;
	logic [26:0] spi_lim;
	logic [26:0] sync_lim;
	logic        spi_wd_on;
	logic        sync_wd_on;
	logic [23:0] slow_raw;
	logic [23:0] slow_filt;
	logic [7:0]  led_src;
	logic [7:0]  led_clr [5];
	logic        supply_err;
	logic        comm_err;
	logic        diag_fault;
	link_ev_t    ev;

	// Strap, CRC, address and sync pins pass two flops before use
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			pin_meta_r  <= 5'h00;
			pin_r       <= 5'h00;
			sync_prev_r <= 1'b0;
			ev_sync_r   <= 3'b000;
			ack_sync_r  <= 2'b00;
		end else begin
			pin_meta_r  <= {strap_mode_i, crc_enable_pin_i, addr0_wd_enable_pin_i, addr1_sync_wd_enable_pin_i, sync_i};
			pin_r       <= pin_meta_r;
			sync_prev_r <= pin_r[0];
			ev_sync_r   <= {ev_sync_r[1:0], ev_tog_r};
			ack_sync_r  <= {ack_sync_r[0], ack_tog_r};
		end
	end
	assign strap      = pin_r[4];
	assign crc_en     = pin_r[3];
	assign ev         = ev_word_r;
	assign frame_seen = ev_sync_r[2] != ev_sync_r[1];
	assign clr_global = frame_seen && !ev.wr && ev.addr == OFS_GLOBAL;

	// Configuration writes from completed frames
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			led_cfg_r <= RST_LED_CFG;
			wd_cfg_r  <= RST_WD_CFG;
			mask_r    <= RST_MASK;
		end else if (frame_seen && ev.wr) begin
			if (ev.addr == OFS_LED_CFG)
				led_cfg_r <= ev.data;
			if (ev.addr == OFS_WD_CFG)
				wd_cfg_r <= ev.data;
			if (ev.addr == OFS_MASK)
				mask_r <= ev.data;
		end
	end

	// Snapshot published only after the link side took the last one
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			snap_r     <= '0;
			snap_tog_r <= 1'b0;
		end else if (ack_sync_r[1] == snap_tog_r) begin
			snap_r.diag    <= flags_r;
			snap_r.glob    <= {spi_wd_err_r, sync_wd_err_r, 1'b0, supply_uvlo_i, supply_warn_flag_i,
			                   supply_not_good_flag_i, 2'b00};
			snap_r.led_cfg <= led_cfg_r;
			snap_r.wd_cfg  <= wd_cfg_r;
			snap_r.mask    <= mask_r;
			snap_tog_r     <= ~snap_tog_r;
		end
	end

	// Blanking choice for open-wire and short flags, and for the LED path
	assign diag_lim = !led_cfg_r[LC_FILTER] ? 20'(DEGLITCH) :                      // [R5]
	                  led_cfg_r[LC_LONG] ? 20'(BLANK_LONG) : 20'(BLANK_SHORT);     // [R4]
	assign led_lim  = led_cfg_r[LC_LONG] ? 20'(BLANK_LONG) : 20'(BLANK_SHORT);     // [R6]
	assign slow_raw = {diag_raw_i.open_off, diag_raw_i.open_on, diag_raw_i.short_supply};

	// Per-bit persistence filters on the slow diagnostics
	always_ff @(posedge mclk_i) begin
		for (int i = 0; i < 24; i++) begin
			if (rst_i)
				filt_cnt_r[i] <= 20'h00000;
			else
				filt_cnt_r[i] <= filt_step(slow_raw[i], filt_cnt_r[i], diag_lim);
		end
	end
	always_comb begin
		for (int i = 0; i < 24; i++)
			slow_filt[i] = filt_cnt_r[i] >= diag_lim;
	end

	// Read clears only bits the reader actually saw, so a new event still wins
	always_comb begin
		for (int k = 0; k < 5; k++)
			led_clr[k] = (frame_seen && !ev.wr && ev.addr == OFS_OVERLOAD + 7'(k)) ? ev.data : 8'h00;
	end

	// Flags are live copies, or sticky with clear on read when latching is on
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			flags_r <= '0;
		end else if (led_cfg_r[LC_LATCH]) begin
			flags_r.overload     <= (flags_r.overload & ~led_clr[0]) | diag_raw_i.overload;           // [R2]
			flags_r.overcurrent  <= (flags_r.overcurrent & ~led_clr[1]) | diag_raw_i.overcurrent;     // [R2]
			flags_r.open_off     <= (flags_r.open_off & ~led_clr[2]) | slow_filt[23:16];              // [R2]
			flags_r.open_on      <= (flags_r.open_on & ~led_clr[3]) | slow_filt[15:8];                // [R2]
			flags_r.short_supply <= (flags_r.short_supply & ~led_clr[4]) | slow_filt[7:0];            // [R2]
		end else begin
			flags_r <= {diag_raw_i.overload, diag_raw_i.overcurrent, slow_filt};
		end
	end

	// Internal LED source works from live conditions, never from the latched flags
	always_comb begin
		if (strap)
			led_src = diag_raw_i.overload;                                              // [R10] [R1]
		else
			led_src = diag_raw_i.overload | (diag_raw_i.overcurrent & {8{~led_cfg_r[LC_OC_MASK]}})  // [R1]
			        | diag_raw_i.open_off | diag_raw_i.open_on | diag_raw_i.short_supply;  // [R10]
	end
	assign stretch_lim = strap ? 29'(2 * STRETCH) :                                    // [R8]
	                     29'(STRETCH) * 29'(led_cfg_r[LC_STRETCH +: 2]);              // [R7]

	// LED turn-on blanking and minimum on-time per channel
	always_ff @(posedge mclk_i) begin
		for (int i = 0; i < 8; i++) begin
			if (rst_i) begin
				led_cnt_r[i] <= 20'h00000;
				stretch_r[i] <= 29'h00000000;
			end else begin
				led_cnt_r[i] <= filt_step(led_src[i], led_cnt_r[i], led_lim);          // [R6]
				if (led_cnt_r[i] >= led_lim && stretch_r[i] == 29'h00000000)
					stretch_r[i] <= 29'h00000001;                                       // [R3]
				else if (stretch_r[i] != 29'h00000000 && stretch_r[i] < stretch_lim)
					stretch_r[i] <= stretch_r[i] + 29'h00000001;                        // [R3]
				else if (led_cnt_r[i] < led_lim)
					stretch_r[i] <= 29'h00000000;
			end
		end
	end

	// LED outputs; the on-time counter above holds a short fault on long enough to see
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			fault_led_o  <= 8'h00;
			status_led_o <= 8'h00;
		end else begin
			for (int i = 0; i < 8; i++)
				fault_led_o[i] <= (led_cfg_r[LC_FAULT_LED_SW] && !strap) ? fault_led_sw_reg_i[i] :       // [R10]
				                  (led_cnt_r[i] >= led_lim) || (stretch_r[i] != 29'h00000000);     // [R3]
			status_led_o <= (led_cfg_r[LC_STATUS_LED_SW] && !strap) ? status_led_sw_reg_i : channel_on_i;  // [R9]
		end
	end

	// Watchdog selection; strap pins enable each one at the longest timeout
	always_comb begin
		case (wd_cfg_r[WC_TIMEOUT +: 2])
			2'b01:   spi_lim = 27'(WD_SHORT);                                          // [R11]
			2'b10:   spi_lim = 27'(WD_MID);
			2'b11:   spi_lim = 27'(WD_LONG);
			default: spi_lim = 27'(WD_MID);
		endcase
		sync_lim   = spi_lim;
		spi_wd_on  = wd_cfg_r[WC_TIMEOUT +: 2] != 2'b00;                                // [R11]
		sync_wd_on = wd_cfg_r[WC_SYNC_EN];
		if (strap) begin
			spi_lim    = 27'(WD_LONG);                                                  // [R12]
			sync_lim   = 27'(WD_LONG);
			spi_wd_on  = pin_r[2];                                                      // [R12]
			sync_wd_on = pin_r[1];
		end
	end

	// Timers restart on each frame or sync edge; errors stick until the global byte is read
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			spi_wd_cnt_r  <= 27'h0000000;
			sync_wd_cnt_r <= 27'h0000000;
			spi_wd_err_r  <= 1'b0;
			sync_wd_err_r <= 1'b0;
		end else begin
			spi_wd_cnt_r  <= (frame_seen || !spi_wd_on) ? 27'h0000000 :
			                 (spi_wd_cnt_r >= spi_lim) ? spi_wd_cnt_r : spi_wd_cnt_r + 27'h0000001;
			sync_wd_cnt_r <= (pin_r[0] != sync_prev_r || !sync_wd_on) ? 27'h0000000 :
			                 (sync_wd_cnt_r >= sync_lim) ? sync_wd_cnt_r : sync_wd_cnt_r + 27'h0000001;
			spi_wd_err_r  <= (spi_wd_on && spi_wd_cnt_r == spi_lim - 27'h0000001) || (spi_wd_err_r && !clr_global);
			sync_wd_err_r <= (sync_wd_on && sync_wd_cnt_r == sync_lim - 27'h0000001) || (sync_wd_err_r && !clr_global);
		end
	end

	// Aggregated supply and comm errors
	assign supply_err = supply_uvlo_i | ((supply_not_good_flag_i | supply_warn_flag_i) & ~mask_r[MK_OK]);  // [R20]
	assign comm_err   = spi_wd_err_r | sync_wd_err_r;
	assign diag_fault = |(flags_r.overload & {8{~mask_r[MK_OVL]}})
	                  | (!strap && |(flags_r.overcurrent & {8{~mask_r[MK_OC]}}))
	                  | (!strap && |(flags_r.open_off & {8{~mask_r[MK_OPEN_OFF]}}))
	                  | (!strap && |(flags_r.open_on & {8{~mask_r[MK_OPEN_ON]}}))
	                  | (!strap && |(flags_r.short_supply & {8{~mask_r[MK_SHORT]}}));

	// Fault pin and status outputs; fault pin drives low while active
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			fault_out_o                <= 1'b0;
			fault_oe_o                 <= 1'b0;
			comm_error_flag_o          <= 1'b0;
			supply_error_flag_o        <= 1'b0;
			global_flag_o              <= 1'b0;
			voltage_error_bit_o        <= 1'b0;
			diag_flags_o               <= '0;
			pullup_current_sel_o       <= 2'b00;
			short_thresh_sel_o         <= 2'b00;
			turn_on_threshold_select_o <= 1'b0;
		end else begin
			fault_out_o         <= 1'b0;
			fault_oe_o          <= diag_fault                                           // [R21]
			                     | (comm_err && !mask_r[MK_COMM] && !strap)             // [R16] [R17]
			                     | (supply_err && !mask_r[MK_SUPPLY] && !strap);        // [R18] [R19]
			comm_error_flag_o   <= comm_err && (!strap || crc_en);                      // [R16] [R17]
			supply_error_flag_o <= supply_err;                                          // [R18]
			global_flag_o       <= comm_err | supply_err | (|flags_r);                  // [R16] [R18]
			voltage_error_bit_o <= strap && crc_en && supply_uvlo_i;                    // [R19]
			diag_flags_o        <= flags_r;
			pullup_current_sel_o       <= wd_cfg_r[WC_PULLUP +: 2];                    // [R13]
			short_thresh_sel_o         <= wd_cfg_r[WC_SHORT +: 2];                     // [R14]
			turn_on_threshold_select_o <= wd_cfg_r[WC_TURN_ON] | strap;                // [R15]
		end
	end

endmodule : diag_led_watchdog_config_regs

// ===== diag_spi_host.sv
`timescale 1ns/10ps
// Host frame master with an 80 ns serial clock
module diag_spi_host (
	output logic      sclk_o,
	output logic      cs_n_o,
	output logic      sdi_o,
	input  wire logic sdo_i
);
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		sdi_o = 1'b0;
	end
	// Clock stands low between frames; data moves only while it is low
	task automatic xfer(input logic [15:0] w, output logic [7:0] r);
		r = 8'h00;
		#7 cs_n_o = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			sdi_o = w[i];
			#40 sclk_o = 1'b1;
			#40 sclk_o = 1'b0;
			if (i > 0 && i < 9) r = {r[6:0], sdo_i}; // Reply follows rising edges 8 to 15
		end
		#40 cs_n_o = 1'b1;
		sdi_o = ~sdi_o; // Released line never keeps a stale copy
		#80;
	endtask : xfer
endmodule : diag_spi_host

// ===== test_diag_led_watchdog_config_regs.sv
`timescale 1ns/10ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fails++; $display("MISMATCH %0t %h %h", $time, a, e); end end
module test_diag_led_watchdog_config_regs;
	import diag_cfg_pkg::*;
	logic        mclk_i = '0, rst_i = '1, sclk_i, cs_n_i, sdi_i, sdo_o, sync_i = '0;
	logic        strap_mode_i = '0, crc_enable_pin_i = '0, supply_uvlo_i = '0, supply_not_good_flag_i = '0;
	logic        addr0_wd_enable_pin_i = '0, addr1_sync_wd_enable_pin_i = '0; // Board leaves enables open
	logic        supply_warn_flag_i = '0, fault_oe_o, turn_on_threshold_select_o, voltage_error_bit_o;
	logic        comm_error_flag_o, supply_error_flag_o;
	logic [7:0]  channel_on_i = '0, status_led_sw_reg_i = '0, fault_led_sw_reg_i = '0, fault_led_o, status_led_o, r;
	logic [1:0]  pullup_current_sel_o, short_thresh_sel_o;
	diag_t       diag_raw_i = '0;
	logic [15:0] lf = 16'h0927;
	logic [6:0]  adr[4] = '{7'h0d, 7'h0e, 7'h0f, 7'h1a};
	logic [7:0]  cfg[5] = '{8'hd2, 8'hd6, 8'hda, 8'hde, 8'he6};
	int          lo[5] = '{1, 90, 190, 290, 0};
	int          hi[5] = '{70, 110, 210, 310, 0};
	int          fails = 0, compares = 0, cyc = 0, dur, bad;
	int          rm[int];

	diag_led_watchdog_config_regs #(.BLANK_SHORT(40), .BLANK_LONG(80), .DEGLITCH(5), .STRETCH(100),
		.WD_SHORT(200), .WD_MID(600), .WD_LONG(1200)) uut (.mclk_i, .rst_i, .sclk_i, .cs_n_i, .sdi_i, .sdo_o,
		.sdo_oe_o(), .strap_mode_i, .crc_enable_pin_i, .addr0_wd_enable_pin_i, .addr1_sync_wd_enable_pin_i,
		.sync_i, .diag_raw_i, .channel_on_i, .status_led_sw_reg_i, .fault_led_sw_reg_i, .supply_uvlo_i,
		.supply_not_good_flag_i, .supply_warn_flag_i, .diag_flags_o(), .fault_led_o, .status_led_o,
		.fault_out_o(), .fault_oe_o, .pullup_current_sel_o, .short_thresh_sel_o, .turn_on_threshold_select_o,
		.comm_error_flag_o, .supply_error_flag_o, .global_flag_o(), .voltage_error_bit_o);
	diag_spi_host host (.sclk_o(sclk_i), .cs_n_o(cs_n_i), .sdi_o(sdi_i), .sdo_i(sdo_o));

	always #5 mclk_i = ~mclk_i;
	// Hang guard well above the expected run of some 10000 cycles
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			end_of_test();
		end
	end

	function automatic logic [15:0] nx(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : nx
	task automatic idle(input int n);
		repeat (n) @(negedge mclk_i);
	endtask : idle
	// Register model drops writes to unmapped places
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		host.xfer({1'b1, a, d}, r);
		if (a inside {7'h0d, 7'h0e, 7'h0f}) rm[a] = d;
		idle(6);
	endtask : wr
	task automatic rd(input logic [6:0] a);
		host.xfer({1'b0, a, 8'h00}, r);
		idle(6);
	endtask : rd
	task automatic rdchk(input logic [6:0] a);
		rd(a);
		`CHK(r, rm.exists(a) ? rm[a][7:0] : 8'h00)
	endtask : rdchk
	task automatic end_of_test;
		if (fails == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : end_of_test

	initial begin
		rm[7'h0d] = 8'h53;
		rm[7'h0e] = 8'h00;
		rm[7'h0f] = 8'hbe;
		idle(6);
		rst_i = 1'b0;
		// Reset values, then an ignored unmapped write and a random mask
		for (int p = 0; p < 2; p++) begin
			foreach (adr[i]) rdchk(adr[i]);
			lf = nx(lf);
			wr(7'h1a, lf[7:0]);
			wr(7'h0f, lf[15:8]);
		end
		wr(7'h0f, 8'hbe);
		// Every code of the two-bit analog fields
		for (int k = 0; k < 4; k++) begin
			wr(7'h0e, {2'b00, k[1:0], k[1:0], 1'b0, k[0]});
			`CHK(pullup_current_sel_o, k[1:0])
			`CHK(short_thresh_sel_o, k[1:0])
			`CHK(turn_on_threshold_select_o, k[0])
			rdchk(7'h0e);
		end
		wr(7'h0e, 8'h00);
		// Software LED banks with random patterns
		repeat (4) begin
			lf = nx(lf);
			{status_led_sw_reg_i, fault_led_sw_reg_i} = lf;
			channel_on_i = lf[7:0] ^ lf[15:8];
			idle(4);
			`CHK(status_led_o, status_led_sw_reg_i)
			`CHK(fault_led_o, fault_led_sw_reg_i)
		end
		// Strap mode with the CRC pin and a supply lockout
		{strap_mode_i, crc_enable_pin_i, supply_uvlo_i} = 3'b111;
		idle(10);
		`CHK(turn_on_threshold_select_o, 1'b1)
		`CHK(voltage_error_bit_o, 1'b1)
		`CHK(fault_oe_o, 1'b0)
		`CHK(fault_led_o, 8'h00)
		`CHK(status_led_o, channel_on_i)
		addr0_wd_enable_pin_i = 1'b1;
		addr1_sync_wd_enable_pin_i = 1'b1;
		idle(1250);
		`CHK(comm_error_flag_o, 1'b1)
		`CHK(fault_oe_o, 1'b0)
		crc_enable_pin_i = 1'b0;
		idle(10);
		`CHK(voltage_error_bit_o, 1'b0)
		`CHK(comm_error_flag_o, 1'b0)
		{strap_mode_i, supply_uvlo_i} = 2'b00;
		rd(7'h09);
		// Shortest SPI watchdog left to expire; the comm mask keeps the pin quiet
		wr(7'h0e, 8'h40);
		idle(260);
		`CHK(comm_error_flag_o, 1'b1)
		`CHK(fault_oe_o, 1'b0)
		wr(7'h0e, 8'h00);
		rd(7'h09);
		`CHK(r, 8'h80)
		`CHK(comm_error_flag_o, 1'b0)
		// Supply not-good under three settings of the supply and supply-OK masks
		supply_not_good_flag_i = 1'b1;
		idle(10);
		`CHK(supply_error_flag_o, 1'b0)
		wr(7'h0f, 8'h9e);
		`CHK(supply_error_flag_o, 1'b1)
		`CHK(fault_oe_o, 1'b1)
		supply_uvlo_i = 1'b1;
		wr(7'h0f, 8'hde);
		`CHK(fault_oe_o, 1'b0)
		`CHK(supply_error_flag_o, 1'b1)
		{supply_not_good_flag_i, supply_uvlo_i} = 2'b00;
		wr(7'h0f, 8'hbe);
		rd(7'h09);
		// Short overload pulse: the sticky flag holds the pin until read
		diag_raw_i.overload = 8'h04;
		idle(20);
		diag_raw_i = '0;
		idle(20);
		`CHK(fault_oe_o, 1'b1)
		rd(7'h04);
		`CHK(r, 8'h04)
		rd(7'h04);
		`CHK(r, 8'h00)
		`CHK(fault_oe_o, 1'b0)
		// Internal fault LEDs: each stretch code, then long blanking outlasting a 60-cycle fault
		foreach (cfg[i]) begin
			wr(7'h0d, cfg[i]);
			diag_raw_i.overload = 8'h01;
			diag_raw_i.overcurrent = 8'h02;
			dur = 0;
			bad = 0;
			for (int c = 0; c < 460; c++) begin
				@(negedge mclk_i);
				if (c == 60) diag_raw_i = '0;
				dur += (fault_led_o[0] === 1'b1);
				bad |= (fault_led_o[1] !== 1'b0);
			end
			`CHK(dur >= lo[i] && dur <= hi[i], 1'b1)
			`CHK(bad, 0)
			rd(7'h04);
		end
		end_of_test();
	end
endmodule : test_diag_led_watchdog_config_regs
